/* File: core/sem_host.sv */
`timescale 1ns/1ps
// Functional notes
// - Semaphore space reached only with select low; address, enables, read/write as SRAM.
// - Flags active low; write zero to request, write one from same side to release.
// - Polling port takes select or output enable inactive between reads.
// - Requester writes zero first, then reads back; never read then write.
// - After a failed request keep reading or write one to withdraw.
// - Software writes one to all eight flags at start-up.
// - Semaphore access keeps memory chip enable high while select is low.
module sem_host
    import sem_host_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic cmd_valid, // Command offered
    input sem_host_pkg::sem_cmd_t cmd, // Operation, flag index, wait option
    output logic cmd_ready, // Engine idle, command accepted
    output logic done, // One-cycle end of command
    output sem_host_pkg::sem_result_t result, // Ownership and last word read
    output sem_host_pkg::sem_pins_t pins, // Port control and address pins
    output logic [sem_host_pkg::DATA_W-1:0] data_out, // Data pin drive
    output logic data_oe, // High while driving data pins
    input wire logic [sem_host_pkg::DATA_W-1:0] data_in // Data pin level
);
    import sem_host_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_STROBE,
        S_SAMPLE,
        S_END
    } state_t;

    state_t state_q, state_d;
    sem_op_t op_q, op_d;
    logic [INDEX_W-1:0] idx_q, idx_d;
    logic wait_q, wait_d;
    logic write_q, write_d;
    logic wval_q, wval_d;
    logic withdraw_q, withdraw_d;
    logic [3:0] cnt_q, cnt_d;
    logic [4:0] polls_q, polls_d;
    logic done_q, done_d;
    sem_result_t res_q, res_d;
    sem_pins_t pins_q, pins_d;
    logic [DATA_W-1:0] dout_q, dout_d;
    logic doe_q, doe_d;
    logic [DATA_W-1:0] sync1_q, sync2_q;
    logic accept;

    assign cmd_ready = (state_q == S_IDLE);
    assign accept = cmd_valid && cmd_ready;
    assign done = done_q;
    assign result = res_q;
    assign pins = pins_q;
    assign data_out = dout_q;
    assign data_oe = doe_q;

    // Data pins come from the device's own timing, so two flops before use
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1_q <= DATA_RESET;
            sync2_q <= DATA_RESET;
        end else begin
            sync1_q <= data_in;
            sync2_q <= sync1_q;
        end
    end

    // Access sequencer: one semaphore cycle per pass, decided again at S_END
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        idx_d = idx_q;
        wait_d = wait_q;
        write_d = write_q;
        wval_d = wval_q;
        withdraw_d = withdraw_q;
        cnt_d = cnt_q;
        polls_d = polls_q;
        done_d = 1'b0;
        res_d = res_q;
        case (state_q)
            S_IDLE: begin
                if (accept) begin
                    op_d = cmd.op;
                    idx_d = (cmd.op == OP_INIT) ? '0 : cmd.index;
                    wait_d = cmd.wait_win;
                    withdraw_d = 1'b0;
                    polls_d = '0;
                    write_d = (cmd.op != OP_READ);
                    wval_d = (cmd.op != OP_ACQUIRE);
                    state_d = S_ADDR;
                end
            end
            S_ADDR: begin
                cnt_d = write_q ? 4'(WRITE_CYC - 1) : 4'(READ_CYC - 1);
                state_d = S_STROBE;
            end
            S_STROBE: begin
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 4'h1;
                end else if (write_q) begin
                    state_d = S_END;
                end else begin
                    cnt_d = 4'(SYNC_CYC - 1);
                    state_d = S_SAMPLE;
                end
            end
            S_SAMPLE: begin
                // Output enable stays low until the word has crossed both flops
                if (cnt_q != '0) begin
                    cnt_d = cnt_q - 4'h1;
                end else begin
                    res_d.word = sync2_q;
                    state_d = S_END;
                end
            end
            S_END: begin
                // Select and enables are high here, so the next read re-captures
                state_d = S_IDLE;
                case (op_q)
                    OP_INIT: begin
                        if (idx_q != LAST_INDEX) begin
                            idx_d = idx_q + 3'h1;
                            state_d = S_ADDR;
                        end else begin
                            done_d = 1'b1;
                        end
                    end
                    OP_ACQUIRE: begin
                        if (write_q && !withdraw_q) begin
                            write_d = 1'b0;
                            state_d = S_ADDR;
                        end else if (withdraw_q) begin
                            res_d.granted = 1'b0;
                            done_d = 1'b1;
                        end else if (!res_q.word[0]) begin
                            res_d.granted = 1'b1;
                            done_d = 1'b1;
                        end else if (wait_q && polls_q != POLL_LIMIT) begin
                            polls_d = polls_q + 5'h1;
                            state_d = S_ADDR;
                        end else begin
                            // A stale request would hand us the token later
                            write_d = 1'b1;
                            wval_d = 1'b1;
                            withdraw_d = 1'b1;
                            state_d = S_ADDR;
                        end
                    end
                    OP_RELEASE: begin
                        res_d.granted = 1'b0;
                        done_d = 1'b1;
                    end
                    default: begin
                        done_d = 1'b1;
                    end
                endcase
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // Pin drive follows the next state so pins change on the same edge
    always_comb begin
        pins_d = PINS_IDLE;
        doe_d = 1'b0;
        dout_d = {15'h0000, wval_d};
        pins_d.addr = {13'h0000, idx_d};
        if (state_d == S_ADDR || state_d == S_STROBE || state_d == S_SAMPLE) begin
            pins_d.sem_n = 1'b0;
            pins_d.ce_n = 1'b1;
            doe_d = write_d;
            if (state_d != S_ADDR) begin
                pins_d.rw_n = !write_d;
                pins_d.oe_n = write_d;
            end
        end
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= S_IDLE;
            op_q <= OP_READ;
            idx_q <= '0;
            wait_q <= 1'b0;
            write_q <= 1'b0;
            wval_q <= 1'b1;
            withdraw_q <= 1'b0;
            cnt_q <= '0;
            polls_q <= '0;
            done_q <= 1'b0;
            res_q <= '0;
            pins_q <= PINS_IDLE;
            dout_q <= DATA_RESET;
            doe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            idx_q <= idx_d;
            wait_q <= wait_d;
            write_q <= write_d;
            wval_q <= wval_d;
            withdraw_q <= withdraw_d;
            cnt_q <= cnt_d;
            polls_q <= polls_d;
            done_q <= done_d;
            res_q <= res_d;
            pins_q <= pins_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
        end
    end

    // Checks on the pin protocol
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_ce_off;
        !pins_q.sem_n |-> pins_q.ce_n;
    endproperty
    a_ce_off: assert property (p_ce_off) else $error("ce_n low during semaphore access");

    property p_strobe_sel;
        (!pins_q.rw_n || !pins_q.oe_n) |-> !pins_q.sem_n && (pins_q.rw_n || pins_q.oe_n);
    endproperty
    a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");

    property p_read_gap;
        $rose(pins_q.oe_n) |-> pins_q.sem_n ##1 pins_q.oe_n;
    endproperty
    a_read_gap: assert property (p_read_gap) else $error("no deselect between reads");

    property p_write_first;
        // Idle, address, then strobe: the first strobe of an acquire is a write
        (accept && cmd.op == OP_ACQUIRE) |-> (pins_q.oe_n)[*3] ##0 !pins_q.rw_n;
    endproperty
    a_write_first: assert property (p_write_first) else $error("acquire did not write first");

    property p_request_zero;
        (!pins_q.rw_n && op_q == OP_ACQUIRE && !withdraw_q) |-> doe_q && !dout_q[0];
    endproperty
    a_request_zero: assert property (p_request_zero) else $error("request not zero");

    property p_release_one;
        (!pins_q.rw_n && op_q != OP_ACQUIRE) || (!pins_q.rw_n && withdraw_q) |->
            doe_q && dout_q[0];
    endproperty
    a_release_one: assert property (p_release_one) else $error("release not one");

    property p_withdraw;
        (state_q == S_END && op_q == OP_ACQUIRE && !write_q && res_q.word[0] && !wait_q)
            |-> ##1 (state_q == S_ADDR && write_q && wval_q) ##1 (!pins_q.rw_n)[*2];
    endproperty
    a_withdraw: assert property (p_withdraw) else $error("failed request not withdrawn");

    property p_init_all;
        (done_q && op_q == OP_INIT) |-> idx_q == LAST_INDEX;
    endproperty
    a_init_all: assert property (p_init_all) else $error("init ended early");

    c_granted: cover property (done_q && op_q == OP_ACQUIRE && res_q.granted);
    c_failed: cover property (done_q && op_q == OP_ACQUIRE && !res_q.granted);
    c_init: cover property (done_q && op_q == OP_INIT);
    c_poll: cover property (polls_q == 5'h2);

endmodule

/* File: core/sem_host_pkg.sv */
package sem_host_pkg;

    // Clock and pin timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WRITE_PULSE_NS = 20;
    localparam int T_READ_ACCESS_NS = 20;
    localparam int WRITE_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC = 2;

    // Widths, counts and reset values
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int INDEX_W = 3;
    localparam logic [INDEX_W-1:0] LAST_INDEX = 3'h7;
    localparam logic [4:0] POLL_LIMIT = 5'h10;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

    typedef enum logic [1:0] {
        OP_INIT,
        OP_ACQUIRE,
        OP_RELEASE,
        OP_READ
    } sem_op_t;

    typedef struct packed {
        sem_op_t op;
        logic [INDEX_W-1:0] index;
        logic wait_win;
    } sem_cmd_t;

    typedef struct packed {
        logic granted;
        logic [DATA_W-1:0] word;
    } sem_result_t;

    typedef struct packed {
        logic sem_n;
        logic ce_n;
        logic rw_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
    } sem_pins_t;

    localparam sem_pins_t PINS_IDLE = '{sem_n: 1'b1, ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
                                        addr: 16'h0000};

endpackage

/* File: test/sem_dev_model.sv */
`timescale 1ns/1ps
// Behavioural flag unit; the far port is driven by the bench on r_we/r_idx/r_bit.
module sem_dev_model
    import sem_host_pkg::*;
(
    input wire logic core_clk, // Model clock
    input wire logic reset, // Model reset, frees all latches
    input sem_host_pkg::sem_pins_t pins, // Host port controls
    input wire logic [sem_host_pkg::DATA_W-1:0] host_dq, // Resolved data wire
    output logic [sem_host_pkg::DATA_W-1:0] dq_to_host, // Device data drive
    input wire logic r_we, // Far port write strobe
    input wire logic [2:0] r_idx, // Far port flag index
    input wire logic r_bit, // Far port write value
    output logic [7:0] l_view, // Flags as the host side sees them
    output logic [7:0] r_view // Flags as the far side sees them
);
    import sem_host_pkg::*;
    logic [7:0] l_req, r_req, l_own, r_own;
    logic prev_rw, rd_act, cap;
    logic [15:0] last;
    logic [4:0] log[$]; // {write, bit, index} of each host access

    // Request latches feed the flag; first zero wins, release hands over
    task automatic apply(input logic side_r, input logic [2:0] i, input logic b);
        if (side_r) begin
            r_req[i] = b;
        end else begin
            l_req[i] = b;
        end
        if (!l_own[i] && !r_own[i]) begin
            l_own[i] = !b && !side_r;
            r_own[i] = !b && side_r;
        end else if (b && (side_r ? r_own[i] : l_own[i])) begin
            r_own[i] = side_r ? 1'b0 : !r_req[i];
            l_own[i] = side_r ? !l_req[i] : 1'b0;
        end // Non-holder writes leave the flag alone
    endtask

    assign l_view = ~l_own;
    assign r_view = ~r_own;
    // Released bus shows the inverse of the last word, never a stale copy
    assign dq_to_host = rd_act ? {16{cap}} : ~last;

    // Sampled per clock; reads land one cycle late, a deliberately slow answer
    always @(posedge core_clk) begin
        if (reset) begin
            l_req = 8'hFF;
            r_req = 8'hFF;
            l_own = 8'h00;
            r_own = 8'h00;
            last = 16'h0000;
        end else begin
            if (r_we) apply(1'b1, r_idx, r_bit);
            // Only select low reaches the flags; standby does nothing
            if (!pins.sem_n && pins.ce_n && !pins.rw_n && prev_rw) begin
                apply(1'b0, pins.addr[2:0], host_dq[0]);
                log.push_back({2'b11 & {1'b1, host_dq[0]}, pins.addr[2:0]});
            end
            if (!pins.sem_n && !pins.oe_n && !rd_act) begin
                // Read the latch itself; the view net may lag a far write in this step
                cap = !l_own[pins.addr[2:0]];
                log.push_back({2'b00, pins.addr[2:0]});
            end
            if (rd_act) last = {16{cap}};
        end
        prev_rw = pins.rw_n;
        rd_act = !reset && !pins.sem_n && !pins.oe_n;
    end
endmodule

/* File: test/dual_port_semaphore_flags_tb_top.sv */
`timescale 1ns/1ps
module dual_port_semaphore_flags_tb_top;
    import sem_host_pkg::*;
    logic core_clk, reset, cmd_valid, r_we, r_bit, cmd_ready, done, data_oe;
    logic [2:0] r_idx;
    logic [7:0] l_view, r_view;
    logic [DATA_W-1:0] data_out, dev_dq, dq_bus;
    sem_cmd_t cmd;
    sem_result_t result;
    sem_pins_t pins;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;

    // Wire level: host wins only while it enables its drivers
    assign dq_bus = data_oe ? data_out : dev_dq;

    sem_host dut_u (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .done(done), .result(result), .pins(pins),
        .data_out(data_out), .data_oe(data_oe), .data_in(dq_bus));
    sem_dev_model dev_u (.core_clk(core_clk), .reset(reset), .pins(pins), .host_dq(dq_bus),
        .dq_to_host(dev_dq), .r_we(r_we), .r_idx(r_idx), .r_bit(r_bit),
        .l_view(l_view), .r_view(r_view));

    task automatic check_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_bit(input string nm, input logic e, input logic g);
        check_word(nm, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic check_log(input int n, input logic [4:0] e);
        check_word("access log", {11'h000, e}, {11'h000, dev_u.log[n]});
    endtask

    task automatic run_cmd(input sem_op_t op, input logic [2:0] i, input logic w);
        dev_u.log.delete();
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, index: i, wait_win: w};
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        @(negedge core_clk);
        check_bit("busy", 1'b0, cmd_ready);
        for (int k = 0; k < 400 && done !== 1'b1; k++) @(negedge core_clk);
        check_bit("done", 1'b1, done);
        check_bit("ready", 1'b1, cmd_ready);
    endtask

    // Far side writes take one clock
    task automatic right_wr(input logic [2:0] i, input logic b);
        @(posedge core_clk);
        r_we <= 1'b1;
        r_idx <= i;
        r_bit <= b;
        @(posedge core_clk);
        r_we <= 1'b0;
    endtask

    task automatic t_init();
        run_cmd(OP_INIT, 3'h0, 1'b0);
        for (int i = 0; i < 8; i++) check_log(i, {2'b11, 3'(i)});
        $display("test init finished");
    endtask

    task automatic t_win();
        run_cmd(OP_ACQUIRE, 3'h5, 1'b0);
        check_log(0, 5'h15);
        check_log(1, 5'h05);
        check_bit("granted", 1'b1, result.granted);
        check_word("word", 16'h0000, result.word);
        check_bit("far view", 1'b1, r_view[5]);
        $display("test acquire win finished");
    endtask

    task automatic t_fail();
        right_wr(3'h2, 1'b0);
        run_cmd(OP_ACQUIRE, 3'h2, 1'b0);
        check_bit("granted", 1'b0, result.granted);
        check_word("word", 16'hFFFF, result.word);
        check_log(2, 5'h1A);
        check_bit("far view", 1'b0, r_view[2]);
        // Flag five is still ours, so a plain read must bring back all zeros
        run_cmd(OP_READ, 3'h5, 1'b0);
        check_log(0, 5'h05);
        check_word("read word", 16'h0000, result.word);
        $display("test acquire fail finished");
    endtask

    task automatic t_wait();
        int reads;
        reads = 0;
        right_wr(3'h3, 1'b0);
        fork
            run_cmd(OP_ACQUIRE, 3'h3, 1'b1);
            begin
                repeat (40) @(posedge core_clk);
                right_wr(3'h3, 1'b1);
            end
        join
        foreach (dev_u.log[k]) if (dev_u.log[k][4] == 1'b0) reads++;
        check_bit("granted", 1'b1, result.granted);
        check_bit("polled", 1'b1, reads > 1);
        check_bit("far view", 1'b1, r_view[3]);
        $display("test wait handover finished");
    endtask

    task automatic t_release();
        run_cmd(OP_RELEASE, 3'h5, 1'b0);
        check_log(0, 5'h1D);
        check_bit("granted", 1'b0, result.granted);
        check_bit("host view", 1'b1, l_view[5]);
        $display("test release finished");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Pin watch: flag accesses keep memory deselected and use a narrow address and data
    always @(posedge core_clk) begin
        cyc++;
        if (!reset && !pins.sem_n) begin
            check_bit("ce_n", 1'b1, pins.ce_n);
            check_word("addr high", 16'h0000, pins.addr & 16'hFFF8);
        end
        if (!reset && data_oe) check_word("data high", 16'h0000, data_out & 16'hFFFE);
        if (cyc == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        r_we = 1'b0;
        r_idx = 3'h0;
        r_bit = 1'b1;
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        t_init();
        t_win();
        t_fail();
        t_wait();
        t_release();
        tally_and_finish();
    end
endmodule
